// >>> common/lcd_pkg.sv
// Constants, opcodes, field positions and timing of the LCD host command port
// Behaviour
// RQ1: Register select high targets instruction/busy status; low targets selected data register.
// RQ2: Instruction write latches data bits 3..0 only; upper nibble ignored.
// RQ3: Each data write lands in a holding register, then moves to its target.
// RQ4: Memory read instruction fetches RAM byte at cursor into the read holding register.
// RQ5: Six-bit mode register: display, master, blink, cursor, graphic, external glyphs.
// RQ6: Dot register holds pitch and vertical dot count, loaded via holding register.
// RQ7: Status read with select and read high shows busy on data bit 7.
// RQ8: Data writes are refused while busy; host polls busy before writing.
// RQ9: Host may skip polling after the longest cycle time has passed.
// RQ10: Instruction register writes never change the busy flag.
// RQ11: Command is 4-bit code write, then 8-bit data write that executes it.
// RQ12: Sixteen-bit cursor counter addresses RAM, increments after data or bit operations.
// RQ13: Built-in glyph ROM: 192 patterns, 160 of 5x7, 32 of 5x11, 5-bit rows.
// RQ14: External glyph source supports 256 patterns of 8x16 dots.
// RQ15: Character mode cursor appears where cursor address and row counter match.
// RQ16: Host programs mode with code 00h and a byte with top two bits zero.
// RQ17: Graphic mode shows RAM bits directly; character mode expands codes through glyphs.
// RQ18: Chip select high: all bus activity ignored, data bus released.
// RQ19: Transfers qualified by enable strobe; read data driven only during strobe.
// RQ20: Reset returns idle, busy cleared, no instruction selected.
package lcd_pkg;

  // ---------------------------------------------------------------------------
  // Instruction codes of the 13 data registers
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OP_MODE     = 4'h0;
  localparam logic [3:0] OP_PITCH    = 4'h1;
  localparam logic [3:0] OP_CHARS    = 4'h2;
  localparam logic [3:0] OP_DUTY     = 4'h3;
  localparam logic [3:0] OP_CUR_LINE = 4'h4;
  localparam logic [3:0] OP_START_LO = 4'h8;
  localparam logic [3:0] OP_START_HI = 4'h9;
  localparam logic [3:0] OP_CUR_LO   = 4'ha;
  localparam logic [3:0] OP_CUR_HI   = 4'hb;
  localparam logic [3:0] OP_WR_DATA  = 4'hc;
  localparam logic [3:0] OP_RD_DATA  = 4'hd;
  localparam logic [3:0] OP_BIT_CLR  = 4'he;
  localparam logic [3:0] OP_BIT_SET  = 4'hf;

  // ---------------------------------------------------------------------------
  // Mode control bit positions and reset values
  // ---------------------------------------------------------------------------
  localparam int MB_DISPLAY  = 5;
  localparam int MB_MASTER   = 4;
  localparam int MB_BLINK    = 3;
  localparam int MB_CURSOR   = 2;
  localparam int MB_GRAPHIC  = 1;
  localparam int MB_EXTERNAL = 0;
  localparam logic [5:0]  MODE_RST  = 6'h00;
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] ADDR_RST  = 16'h0000;
  localparam int BUSY_BIT = 7;

  // ---------------------------------------------------------------------------
  // Glyph geometry
  // ---------------------------------------------------------------------------
  localparam int GLYPH_COUNT = 192;
  localparam int GLYPH_SMALL = 160;
  localparam int SMALL_ROWS  = 7;
  localparam int LARGE_ROWS  = 11;
  localparam int GLYPH_COLS  = 5;
  localparam int EXT_GLYPHS  = 256;
  localparam int EXT_ROWS    = 16;

  // ---------------------------------------------------------------------------
  // Timing: internal execution time of one command
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ  = 100;
  localparam int EXEC_NS  = 40;
  localparam int EXEC_CYC = (EXEC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] EXEC_LAST = 4'(EXEC_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_EXEC  = 3'b001,
    ST_FETCH = 3'b011,
    ST_LATCH = 3'b010,
    ST_STORE = 3'b110
  } port_state_t;

endpackage

// >>> hw/pin_sync.sv
// Two-flop synchroniser for the asynchronous host pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int              W         = 1,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RST_N,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] ASYNC_IN,
  output      logic [W-1:0] SYNC_OUT
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q   <= RESET_VAL;
      SYNC_OUT <= RESET_VAL;
    end else begin
      meta_q   <= ASYNC_IN;
      SYNC_OUT <= meta_q;
    end
  end

endmodule

// >>> hw/glyph_rom.sv
// Built-in glyph pattern store: 192 codes, 5-dot rows
`timescale 1ns/1ps
module glyph_rom
  import lcd_pkg::*;
(
  // Lookup address
  input  wire logic [7:0] CODE,
  input  wire logic [3:0] ROW,
  // Dot row
  output      logic [4:0] DOTS
);

  // One 5-bit row per entry; small glyphs use 7 rows, large ones 11
  logic [4:0] rom [GLYPH_COUNT][LARGE_ROWS];

  // Pattern generator stands in for the mask font; swap for the real table
  for (genvar c = 0; c < GLYPH_COUNT; c++) begin : g_code
    for (genvar r = 0; r < LARGE_ROWS; r++) begin : g_row
      localparam int ROWS = (c < GLYPH_SMALL) ? SMALL_ROWS : LARGE_ROWS;
      assign rom[c][r] = (r < ROWS) ? 5'(c ^ (r * 3)) : 5'h00; // [RQ13]
    end
  end

  // Codes above 191 and rows past the glyph height are blank
  always_comb begin
    if (CODE < 8'(GLYPH_COUNT) && ROW < 4'(LARGE_ROWS)) begin
      DOTS = rom[CODE][ROW];
    end else begin
      DOTS = 5'h00;
    end
  end

endmodule

// >>> hw/lcd_host_port.sv
// Host command port of the dot-matrix LCD controller with display dot path
`timescale 1ns/1ps
module lcd_host_port
  import lcd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Host parallel bus pins
  input  wire logic        REG_SELECT,
  input  wire logic        READ_WRITE,
  input  wire logic        ENABLE_STROBE,
  input  wire logic        CHIP_SEL_N,
  input  wire logic [7:0]  DATA_IN,
  output      logic [7:0]  DATA_OUT,
  output      logic        DATA_OE,
  // External display RAM port
  output      logic [15:0] RAM_ADDR,
  output      logic [7:0]  RAM_WDATA,
  output      logic        RAM_WE,
  output      logic        RAM_RE,
  input  wire logic [7:0]  RAM_RDATA,
  // Status and settings to the scan logic
  output      logic        BUSY,
  output      logic [5:0]  MODE_CTRL,
  output      logic [7:0]  CHAR_PITCH,
  output      logic [7:0]  CHAR_COUNT,
  output      logic [7:0]  DISPLAY_DUTY,
  output      logic [3:0]  CURSOR_LINE,
  output      logic [15:0] START_ADDR,
  // Display scan side
  input  wire logic [15:0] SCAN_ADDR,
  input  wire logic [3:0]  SCAN_ROW,
  input  wire logic [7:0]  SCAN_DATA,
  output      logic [11:0] EXT_GLYPH_ADDR,
  input  wire logic [7:0]  EXT_GLYPH_DATA,
  output      logic [7:0]  DOT_ROW
);

  // ---------------------------------------------------------------------------
  // Pin synchronisation and strobe decode
  // ---------------------------------------------------------------------------
  logic [7:0] s_db;
  logic       s_rs;
  logic       s_rw;
  logic       s_e;
  logic       s_cs_n;
  logic       e_prev_q;
  logic       strobe_end;
  logic       wr_instr;
  logic       wr_data;
  logic       rd_data;
  logic       read_window;

  // Deselected at reset so nothing looks like a transfer
  pin_sync #(.W(12), .RESET_VAL(12'h008)) u_sync (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .ASYNC_IN ({DATA_IN, CHIP_SEL_N, ENABLE_STROBE, READ_WRITE, REG_SELECT}),
    .SYNC_OUT ({s_db, s_cs_n, s_e, s_rw, s_rs})
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      e_prev_q <= 1'b0;
    end else begin
      e_prev_q <= s_e;
    end
  end

  // Falling strobe ends a transfer; data is stable across the strobe
  assign strobe_end  = e_prev_q && !s_e && !s_cs_n;          // [RQ19] [RQ18]
  assign wr_instr    = strobe_end && s_rs && !s_rw;          // [RQ1]
  assign wr_data     = strobe_end && !s_rs && !s_rw;         // [RQ1]
  assign rd_data     = strobe_end && !s_rs && s_rw;
  assign read_window = s_e && !s_cs_n && s_rw;               // [RQ19]

  // ---------------------------------------------------------------------------
  // Command engine
  // ---------------------------------------------------------------------------
  port_state_t state_q, state_d;
  logic [3:0]  instr_q, instr_d;
  logic        instr_ok_q, instr_ok_d;
  logic        busy_q, busy_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  hold_q, hold_d;
  logic [7:0]  rd_hold_q, rd_hold_d;
  logic [7:0]  wdata_q, wdata_d;
  logic [15:0] cursor_q, cursor_d;
  logic [5:0]  mode_q, mode_d;
  logic [7:0]  pitch_q, pitch_d;
  logic [7:0]  chars_q, chars_d;
  logic [7:0]  duty_q, duty_d;
  logic [3:0]  cline_q, cline_d;
  logic [15:0] start_q, start_d;
  logic [7:0]  db_out_q, db_out_d;
  logic        oe_q;
  logic [7:0]  bit_mask;

  assign bit_mask = 8'h01 << hold_q[2:0];

  // Next-state logic for the two-write command protocol
  always_comb begin
    state_d    = state_q;
    instr_d    = instr_q;
    instr_ok_d = instr_ok_q;
    busy_d     = busy_q;
    cnt_d      = cnt_q;
    hold_d     = hold_q;
    rd_hold_d  = rd_hold_q;
    wdata_d    = wdata_q;
    cursor_d   = cursor_q;
    mode_d     = mode_q;
    pitch_d    = pitch_q;
    chars_d    = chars_q;
    duty_d     = duty_q;
    cline_d    = cline_q;
    start_d    = start_q;
    // Status read shows busy on bit 7, data read the read holding register
    db_out_d   = s_rs ? {busy_q, 7'h00} : rd_hold_q;                // [RQ7] [RQ1]

    // Code writes are always taken and leave busy alone
    if (wr_instr) begin
      instr_d    = s_db[3:0];                                        // [RQ2] [RQ10]
      instr_ok_d = 1'b1;
    end

    case (state_q)
      ST_IDLE: begin
        if (wr_instr && s_db[3:0] == OP_RD_DATA) begin
          state_d = ST_FETCH;                                        // [RQ4]
        end else if (rd_data && instr_ok_q && instr_q == OP_RD_DATA) begin
          cursor_d = cursor_q + 16'h0001;                            // [RQ12]
          state_d  = ST_FETCH;                                       // [RQ4]
        end else if (wr_data && instr_ok_q) begin                    // [RQ8]
          hold_d  = s_db;                                            // [RQ3] [RQ11]
          busy_d  = 1'b1;
          cnt_d   = EXEC_LAST;
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = ST_IDLE;
          busy_d  = 1'b0;
          case (instr_q)
            OP_MODE:     mode_d          = hold_q[5:0];              // [RQ5] [RQ3]
            OP_PITCH:    pitch_d         = hold_q;                   // [RQ6]
            OP_CHARS:    chars_d         = hold_q;
            OP_DUTY:     duty_d          = hold_q;
            OP_CUR_LINE: cline_d         = hold_q[3:0];
            OP_START_LO: start_d[7:0]    = hold_q;
            OP_START_HI: start_d[15:8]   = hold_q;
            OP_CUR_LO:   cursor_d[7:0]   = hold_q;                   // [RQ12]
            OP_CUR_HI:   cursor_d[15:8]  = hold_q;                   // [RQ12]
            OP_WR_DATA: begin
              wdata_d = hold_q;                                      // [RQ3]
              busy_d  = 1'b1;
              state_d = ST_STORE;
            end
            OP_BIT_CLR, OP_BIT_SET: begin
              busy_d  = 1'b1;
              state_d = ST_FETCH;
            end
            default: begin
              busy_d = 1'b0;
            end
          endcase
        end
      end
      ST_FETCH: begin
        state_d = ST_LATCH;
      end
      ST_LATCH: begin
        // Busy marks a bit operation; otherwise it was a read prefetch
        if (busy_q) begin
          wdata_d = (instr_q == OP_BIT_SET) ? (RAM_RDATA | bit_mask) : (RAM_RDATA & ~bit_mask);
          state_d = ST_STORE;
        end else begin
          rd_hold_d = RAM_RDATA;                                     // [RQ4]
          state_d   = ST_IDLE;
        end
      end
      ST_STORE: begin
        cursor_d = cursor_q + 16'h0001;                              // [RQ12]
        busy_d   = 1'b0;
        state_d  = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  // State registers; reset leaves no code selected and busy clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q    <= ST_IDLE;                                         // [RQ20]
      instr_q    <= OP_MODE;
      instr_ok_q <= 1'b0;                                            // [RQ20]
      busy_q     <= 1'b0;                                            // [RQ20]
      cnt_q      <= 4'h0;
      hold_q     <= BYTE_RST;
      rd_hold_q  <= BYTE_RST;
      wdata_q    <= BYTE_RST;
      cursor_q   <= ADDR_RST;
      mode_q     <= MODE_RST;
      pitch_q    <= BYTE_RST;
      chars_q    <= BYTE_RST;
      duty_q     <= BYTE_RST;
      cline_q    <= 4'h0;
      start_q    <= ADDR_RST;
      db_out_q   <= BYTE_RST;
      oe_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      instr_q    <= instr_d;
      instr_ok_q <= instr_ok_d;
      busy_q     <= busy_d;
      cnt_q      <= cnt_d;
      hold_q     <= hold_d;
      rd_hold_q  <= rd_hold_d;
      wdata_q    <= wdata_d;
      cursor_q   <= cursor_d;
      mode_q     <= mode_d;
      pitch_q    <= pitch_d;
      chars_q    <= chars_d;
      duty_q     <= duty_d;
      cline_q    <= cline_d;
      start_q    <= start_d;
      db_out_q   <= db_out_d;
      oe_q       <= read_window;                                     // [RQ18] [RQ19]
    end
  end

  // RAM strobes follow the state; address always from the cursor counter
  assign RAM_ADDR     = cursor_q;                                    // [RQ12]
  assign RAM_WDATA    = wdata_q;
  assign RAM_WE       = (state_q == ST_STORE);
  assign RAM_RE       = (state_q == ST_FETCH);
  assign DATA_OUT     = db_out_q;
  assign DATA_OE      = oe_q;
  assign BUSY         = busy_q;
  assign MODE_CTRL    = mode_q;
  assign CHAR_PITCH   = pitch_q;
  assign CHAR_COUNT   = chars_q;
  assign DISPLAY_DUTY = duty_q;
  assign CURSOR_LINE  = cline_q;
  assign START_ADDR   = start_q;

  // ---------------------------------------------------------------------------
  // Dot path: graphic bits, glyph expansion and cursor overlay
  // ---------------------------------------------------------------------------
  logic [4:0] rom_dots;
  logic [7:0] dot_row_q, dot_row_d;
  logic       cursor_hit;

  glyph_rom u_glyph (
    .CODE (SCAN_DATA),
    .ROW  (SCAN_ROW),
    .DOTS (rom_dots)
  );

  // External font: 256 codes by 16 rows of 8 dots
  assign EXT_GLYPH_ADDR = {SCAN_DATA, SCAN_ROW};                     // [RQ14]
  assign cursor_hit = mode_q[MB_CURSOR] && !mode_q[MB_GRAPHIC]
                      && SCAN_ADDR == cursor_q && SCAN_ROW == cline_q; // [RQ15]

  // Cursor wins over the glyph row; blink timing lives in the scan logic
  always_comb begin
    if (!mode_q[MB_DISPLAY]) begin
      dot_row_d = 8'h00;
    end else if (mode_q[MB_GRAPHIC]) begin
      dot_row_d = SCAN_DATA;                                         // [RQ17]
    end else if (cursor_hit) begin
      dot_row_d = 8'hff;                                             // [RQ15]
    end else if (mode_q[MB_EXTERNAL]) begin
      dot_row_d = EXT_GLYPH_DATA;                                    // [RQ14] [RQ17]
    end else begin
      dot_row_d = {3'h0, rom_dots};                                  // [RQ13] [RQ17]
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dot_row_q <= BYTE_RST;
    end else begin
      dot_row_q <= dot_row_d;
    end
  end

  assign DOT_ROW = dot_row_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_fetch_steps;
    (state_q == ST_FETCH && !busy_q) ##1 (state_q == ST_LATCH);
  endsequence

  property p_instr_nibble;
    @(posedge CLK) disable iff (!RST_N)
      wr_instr |=> (instr_q == $past(s_db[3:0]) && instr_ok_q);
  endproperty
  a_instr_nibble: assert property (p_instr_nibble) else $error("code latch wrong"); // [RQ2]

  property p_busy_kept;
    @(posedge CLK) disable iff (!RST_N)
      (wr_instr && state_q == ST_IDLE) |=> (busy_q == $past(busy_q));
  endproperty
  a_busy_kept: assert property (p_busy_kept) else $error("code write moved busy"); // [RQ10]

  property p_refuse;
    @(posedge CLK) disable iff (!RST_N)
      (busy_q && wr_data) |=> (hold_q == $past(hold_q));
  endproperty
  a_refuse: assert property (p_refuse) else $error("write taken while busy"); // [RQ8]

  property p_status;
    @(posedge CLK) disable iff (!RST_N)
      (read_window && s_rs) |=> (DATA_OUT == {$past(busy_q), 7'h00} && DATA_OE);
  endproperty
  a_status: assert property (p_status) else $error("busy not on bit 7"); // [RQ7]

  property p_release;
    @(posedge CLK) disable iff (!RST_N)
      (s_cs_n || !s_e) |=> !DATA_OE;
  endproperty
  a_release: assert property (p_release) else $error("bus driven when idle"); // [RQ18]

  property p_store_inc;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_STORE) |-> RAM_WE ##1 (cursor_q == $past(cursor_q) + 16'h0001 && !busy_q);
  endproperty
  a_store_inc: assert property (p_store_inc) else $error("cursor not stepped"); // [RQ12]

  property p_fetch;
    @(posedge CLK) disable iff (!RST_N)
      s_fetch_steps |=> (rd_hold_q == $past(RAM_RDATA) && state_q == ST_IDLE);
  endproperty
  a_fetch: assert property (p_fetch) else $error("read byte not held"); // [RQ4]

  property p_exec;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_IDLE && wr_data && instr_ok_q) |=> busy_q ##[1:12] !busy_q;
  endproperty
  a_exec: assert property (p_exec) else $error("command never completed"); // [RQ11]

  property p_mode;
    @(posedge CLK) disable iff (!RST_N)
      (state_q == ST_EXEC && cnt_q == 4'h0 && instr_q == OP_MODE) |=> (MODE_CTRL == $past(hold_q[5:0]));
  endproperty
  a_mode: assert property (p_mode) else $error("mode not loaded"); // [RQ5]

endmodule

// >>> tb/disp_ram_model.sv
// Behavioural external display RAM on the far side of the host command port
`timescale 1ns/1ps
module disp_ram_model (
  // Clock
  input  wire logic        CLK,
  // Access from the controller
  input  wire logic [15:0] RAM_ADDR,
  input  wire logic [7:0]  RAM_WDATA,
  input  wire logic        RAM_WE,
  input  wire logic        RAM_RE,
  output      logic [7:0]  RAM_RDATA
);
  logic [7:0] mem_q [65536];
  logic [7:0] junk_q = 8'h5a;
  logic [7:0] rdata_q;
  logic       re_q = 1'b0;

  // Store on the write pulse; idle bus keeps flipping so no stale byte survives
  always_ff @(posedge CLK) begin
    if (RAM_WE) begin
      mem_q[RAM_ADDR] <= RAM_WDATA;
    end
    re_q    <= RAM_RE;
    rdata_q <= mem_q[RAM_ADDR];
    junk_q  <= ~RAM_RDATA;
  end

  // Byte stands in the cycle after the read pulse, when the controller latches it
  assign RAM_RDATA = re_q ? rdata_q : junk_q;
endmodule

// >>> tb/tb.sv
// Self-checking bench of the LCD host command port
`timescale 1ns/1ps
module tb;
  import lcd_pkg::*;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
  logic        CLK = 1'b0;
  logic        RST_N, REG_SELECT, READ_WRITE, ENABLE_STROBE, CHIP_SEL_N, DATA_OE, RAM_WE, RAM_RE, BUSY, oe_d;
  logic [7:0]  DATA_IN, DATA_OUT, RAM_WDATA, RAM_RDATA, CHAR_PITCH, CHAR_COUNT, DISPLAY_DUTY, SCAN_DATA;
  logic [7:0]  EXT_GLYPH_DATA, DOT_ROW, last, exp_b, d, d0, d1;
  logic [15:0] RAM_ADDR, START_ADDR, SCAN_ADDR, addr;
  logic [23:0] exp_w;
  logic [43:0] regs_e;
  logic [11:0] EXT_GLYPH_ADDR;
  logic [5:0]  MODE_CTRL, m;
  logic [3:0]  CURSOR_LINE, SCAN_ROW;
  logic [2:0]  n;
  logic [3:0]  codes [6] = '{OP_PITCH, OP_CHARS, OP_DUTY, OP_CUR_LINE, OP_START_LO, OP_START_HI};
  int          errors, total_checks;
  logic [7:0]  rq[$];
  logic [23:0] wq[$];

  // ---------------------------------------------------------------------------
  // Device, RAM and clock
  // ---------------------------------------------------------------------------
  lcd_host_port i_dut (.CLK(CLK), .RST_N(RST_N), .REG_SELECT(REG_SELECT), .READ_WRITE(READ_WRITE),
    .ENABLE_STROBE(ENABLE_STROBE), .CHIP_SEL_N(CHIP_SEL_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_WE(RAM_WE), .RAM_RE(RAM_RE),
    .RAM_RDATA(RAM_RDATA), .BUSY(BUSY), .MODE_CTRL(MODE_CTRL), .CHAR_PITCH(CHAR_PITCH),
    .CHAR_COUNT(CHAR_COUNT), .DISPLAY_DUTY(DISPLAY_DUTY), .CURSOR_LINE(CURSOR_LINE),
    .START_ADDR(START_ADDR), .SCAN_ADDR(SCAN_ADDR), .SCAN_ROW(SCAN_ROW), .SCAN_DATA(SCAN_DATA),
    .EXT_GLYPH_ADDR(EXT_GLYPH_ADDR), .EXT_GLYPH_DATA(EXT_GLYPH_DATA), .DOT_ROW(DOT_ROW));
  disp_ram_model i_ram (.CLK(CLK), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_WE(RAM_WE),
    .RAM_RE(RAM_RE), .RAM_RDATA(RAM_RDATA));
  always #5 CLK = ~CLK;

  // ---------------------------------------------------------------------------
  // Host bus tasks
  // ---------------------------------------------------------------------------
  // Strobe held 3 cycles so the synchroniser sees it; pins stay put until next call
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] dv, input int gap);
    @(negedge CLK);
    REG_SELECT = rs;
    READ_WRITE = rw;
    DATA_IN = dv;
    ENABLE_STROBE = 1'b1;
    repeat (3) @(negedge CLK);
    ENABLE_STROBE = 1'b0;
    repeat (gap) @(negedge CLK);
  endtask
  // Bounded wait on the busy flag before the next data write
  task automatic idle();
    int k = 0;
    while (BUSY !== 1'b0 && k < 40) begin
      @(negedge CLK);
      k++;
    end
    if (k == 40) errors++;
  endtask
  // Code write with junk in the upper nibble, then the data byte
  task automatic cmd(input logic [3:0] c, input logic [7:0] dv);
    xfer(1'b1, 1'b0, {4'($urandom), c}, 5);
    xfer(1'b0, 1'b0, dv, 5);
    idle();
  endtask
  task automatic setcur(input logic [15:0] a);
    cmd(OP_CUR_LO, a[7:0]);
    cmd(OP_CUR_HI, a[15:8]);
  endtask
  task automatic rd(input logic rs, input logic [7:0] e);
    rq.push_back(e);
    xfer(rs, 1'b1, 8'($urandom), 5);
  endtask
  task automatic stop_test();
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Result monitor: read answers and RAM writes against the notes
  // ---------------------------------------------------------------------------
  always @(posedge CLK) begin
    oe_d <= DATA_OE;
    if (DATA_OE === 1'b1) last <= DATA_OUT;
    if (oe_d === 1'b1 && DATA_OE === 1'b0) begin
      exp_b = (rq.size() > 0) ? rq.pop_front() : 8'hxx;
      `CHK(last, exp_b)
    end
    if (RAM_WE === 1'b1) begin
      exp_w = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
      `CHK({RAM_ADDR, RAM_WDATA}, exp_w)
    end
  end

  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    RST_N = 1'b0;
    {REG_SELECT, READ_WRITE, ENABLE_STROBE, CHIP_SEL_N} = 4'b0001;
    {DATA_IN, SCAN_DATA, EXT_GLYPH_DATA, SCAN_ROW, SCAN_ADDR} = '0;
    regs_e = '0;
    void'($urandom(90));
    repeat (8) @(negedge CLK);
    `CHK({BUSY, DATA_OE, MODE_CTRL}, 8'h00)
    RST_N = 1'b1;
    repeat (4) @(negedge CLK);
    CHIP_SEL_N = 1'b0;
    rd(1'b1, 8'h00);
    // Display off blanks the dot path; external glyph address follows scan
    {SCAN_DATA, SCAN_ROW, SCAN_ADDR, EXT_GLYPH_DATA} = 36'({$urandom, $urandom});
    repeat (2) @(negedge CLK);
    `CHK(DOT_ROW, 8'h00)
    `CHK(EXT_GLYPH_ADDR, {SCAN_DATA, SCAN_ROW})
    // Every settings register with random bytes
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      cmd(codes[i], d);
      case (codes[i])
        OP_PITCH: regs_e[43:36] = d;
        OP_CHARS: regs_e[35:28] = d;
        OP_DUTY: regs_e[27:20] = d;
        OP_CUR_LINE: regs_e[19:16] = d[3:0];
        OP_START_LO: regs_e[7:0] = d;
        default: regs_e[15:8] = d;
      endcase
      `CHK({CHAR_PITCH, CHAR_COUNT, DISPLAY_DUTY, CURSOR_LINE, START_ADDR}, regs_e)
    end
    m = 6'($urandom);
    cmd(OP_MODE, {2'b00, m});
    `CHK(MODE_CTRL, m)
    // Two writes across the top of the address space: the counter wraps
    addr = 16'hffff;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    setcur(addr);
    `CHK(BUSY, 1'b0)
    wq.push_back({addr, d0});
    wq.push_back({addr + 16'h1, d1});
    cmd(OP_WR_DATA, d0);
    xfer(1'b0, 1'b0, d1, 5);
    idle();
    // Read back through the prefetching read instruction
    setcur(addr);
    xfer(1'b1, 1'b0, {4'h0, OP_RD_DATA}, 8);
    rd(1'b0, d0);
    rd(1'b0, d1);
    // Bit clear, then bit set with a second data write refused while busy
    n = 3'($urandom);
    setcur(addr);
    wq.push_back({addr, d0 & ~(8'h01 << n)});
    cmd(OP_BIT_CLR, {5'h00, n});
    wq.push_back({addr + 16'h1, d1 | (8'h01 << n)});
    xfer(1'b1, 1'b0, {4'h0, OP_BIT_SET}, 5);
    xfer(1'b0, 1'b0, {5'h00, n}, 2);
    xfer(1'b0, 1'b0, {5'h00, n + 3'h1}, 0);
    `CHK(BUSY, 1'b1)
    idle();
    // Cursor row at the cursor address (two steps past the top), then the external font byte
    cmd(OP_MODE, 8'h24);
    SCAN_ADDR = addr + 16'h2;
    SCAN_ROW = regs_e[19:16];
    repeat (2) @(negedge CLK);
    `CHK(DOT_ROW, 8'hff)
    cmd(OP_MODE, 8'h21);
    repeat (2) @(negedge CLK);
    `CHK(DOT_ROW, EXT_GLYPH_DATA)
    // Graphic mode shows the byte itself; codes past the built-in set are blank
    cmd(OP_MODE, 8'h22);
    repeat (2) @(negedge CLK);
    `CHK(DOT_ROW, SCAN_DATA)
    cmd(OP_MODE, 8'h20);
    SCAN_DATA = 8'hc0 | 8'($urandom);
    repeat (2) @(negedge CLK);
    `CHK(DOT_ROW, 8'h00)
    // Deselected chip ignores writes and never drives a read
    CHIP_SEL_N = 1'b1;
    xfer(1'b1, 1'b0, 8'h00, 5);
    xfer(1'b0, 1'b0, 8'h3f, 5);
    xfer(1'b1, 1'b1, 8'h00, 8);
    `CHK(MODE_CTRL, 6'h20)
    stop_test();
  end
endmodule
